/* File: logic/mode_switch_consts.vh */
// constants for the contact input mode switcher
// assumes a 32-bit apb slave with byte addresses and word registers
`ifndef MODE_SWITCH_CONSTS_VH
`define MODE_SWITCH_CONSTS_VH

// action codes held in each input's configuration field
`define ACT_WIDTH          3
`define ACT_NONE           3'h0
`define ACT_HAND           3'h1
`define ACT_LSP_ONE        3'h2
`define ACT_LSP_TWO        3'h3
`define ACT_LSP_THREE      3'h4
`define ACT_LSP_FOUR       3'h5
`define ACT_FORWARD        3'h6
`define ACT_SUSPEND        3'h7

// per-input configuration field: action then loop allocation
`define CFG_FIELD_WIDTH    4
`define CFG_LOOP_BIT       3

// register byte offsets
`define ADDR_WIDTH         8
`define REG_INPUT_CFG      8'h00
`define REG_LOOP0_CTRL     8'h04
`define REG_LOOP1_CTRL     8'h08
`define REG_STATUS         8'h0C

// loop control fields
`define CTRL_REMOTE_BIT    0
`define CTRL_LSP_LSB       1
`define CTRL_DIRECT_BIT    3
`define CTRL_WIDTH         4
`define CTRL_RESET         4'h0
`define CFG_RESET          32'h0000_0000

// status layout: contacts, annunciators, then per loop state byte
`define STAT_ANN_LSB       4
`define STAT_LOOP_LSB      8
`define STAT_LOOP_WIDTH    8

`define LABEL_WIDTH        2
`define LABEL_RESET        2'h0
`endif

/* File: logic/contact_sync.v */
// two flip-flop synchroniser for a group of pin levels
// assumes inputs are asynchronous to sys_clk and slow moving
module contact_sync #(
    parameter WIDTH = 4
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             reset,
    // levels
    input  wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] stageOne;
reg [WIDTH-1:0] stageTwo;

// per bit, first stage feeds only the second
genvar b;
generate
    for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
        always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                stageOne[b] <= 1'b0;
                stageTwo[b] <= 1'b0;
            end else begin
                stageOne[b] <= asyncIn[b];
                stageTwo[b] <= stageOne[b];
            end
        end
    end
endgenerate

assign syncOut = stageTwo;

endmodule

/* File: logic/contact_input_mode_switcher.v */
// contact input mode switcher: per-input actions on two control loops
// assumes an apb master on sys_clk; contacts and keys arrive from pins
//
// Contract
// R1: an input with an action shows its contact state on its annunciator
// R2: an input with no action keeps annunciator off and does nothing
// R3: on reopening, state before closure returns unless an action says
// R4: hand action closure forces hand mode and blinks hand indicator
// R5: hand reopening restores prior mode, stays hand if key pressed meanwhile
// R6: setpoint selects force local setpoint one to four, blink, show label
// R7: setpoint select reopening restores prior local or remote source
// R8: forward action closure makes control action direct
// R9: suspend closure halts program or ramp and blinks suspend indicator
// R10: suspend reopening resumes only if program was started by its key
// R11: suspend may be allocated to either loop
// R12: each input carries a loop allocation for two-loop setups
// R13: contacts pass two flip-flops before any use
//
// Local design decisions: the APB slave port and the register offsets.
`include "mode_switch_consts.vh"

module contact_input_mode_switcher #(
    parameter NUM_INPUTS = 4,
    parameter NUM_LOOPS  = 2
) (
    // clock and reset
    input  wire                  sys_clk,
    input  wire                  reset,
    // apb slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [31:0]           paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata,
    output wire                  pready,
    output wire                  pslverr,
    // contacts and operator keys, high while closed or pressed
    input  wire [NUM_INPUTS-1:0] contactClosed,
    input  wire [NUM_LOOPS-1:0]  handAutoKey,
    input  wire [NUM_LOOPS-1:0]  programToggleKey,
    // annunciators
    output reg  [NUM_INPUTS-1:0] annunciator,
    // per loop state
    output wire [NUM_LOOPS-1:0]  manualMode,
    output wire [NUM_LOOPS-1:0]  handBlink,
    output wire [NUM_LOOPS-1:0]  remoteSetpoint,
    output wire [NUM_LOOPS*2-1:0] setpointLabel,
    output wire [NUM_LOOPS-1:0]  setpointBlink,
    output wire [NUM_LOOPS-1:0]  directAction,
    output wire [NUM_LOOPS-1:0]  programAdvance,
    output wire [NUM_LOOPS-1:0]  suspendBlink
);

// contacts plus both key groups share one synchroniser
localparam SYNC_WIDTH = NUM_INPUTS + 2 * NUM_LOOPS;

// synchronised levels
wire [SYNC_WIDTH-1:0]  syncLevels;
wire [NUM_INPUTS-1:0]  closed;
wire [NUM_LOOPS-1:0]   handKeyLevel;
wire [NUM_LOOPS-1:0]   progKeyLevel;
reg  [NUM_LOOPS-1:0]   handKeyPrev;
reg  [NUM_LOOPS-1:0]   progKeyPrev;
wire [NUM_LOOPS-1:0]   handKeyPress;
wire [NUM_LOOPS-1:0]   progKeyPress;

// registers
reg  [31:0]            inputCfg;
reg  [`CTRL_WIDTH-1:0] loopCtrl [0:NUM_LOOPS-1];

// bus decode
wire                   setupPhase;
wire                   writeAccess;
wire [`ADDR_WIDTH-1:0] wordAddr;
reg                    addrHit;
reg  [31:0]            readValue;
reg  [31:0]            statusWord;
// per loop state bytes merged into the status word
wire [NUM_LOOPS*`STAT_LOOP_WIDTH-1:0] statusWordLoop;

// contacts and keys through two flops before any use
contact_sync #(
    .WIDTH   (SYNC_WIDTH)
) u_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn ({programToggleKey, handAutoKey, contactClosed}),
    .syncOut (syncLevels)
); // R13

// split the synchronised word back into its parts
assign closed       = syncLevels[NUM_INPUTS-1:0];
assign handKeyLevel = syncLevels[NUM_INPUTS +: NUM_LOOPS];
assign progKeyLevel = syncLevels[NUM_INPUTS+NUM_LOOPS +: NUM_LOOPS];

// key press edges, taken after the synchroniser
always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
        handKeyPrev <= {NUM_LOOPS{1'b0}};
        progKeyPrev <= {NUM_LOOPS{1'b0}};
    end else begin
        handKeyPrev <= handKeyLevel;
        progKeyPrev <= progKeyLevel;
    end
end

// one cycle pulse per key press
assign handKeyPress = handKeyLevel & ~handKeyPrev;
assign progKeyPress = progKeyLevel & ~progKeyPrev;

// annunciators follow configured contacts, unconfigured stay dark
genvar a;
generate
    for (a = 0; a < NUM_INPUTS; a = a + 1) begin : g_ann
        always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                annunciator[a] <= 1'b0;
            end else begin
                annunciator[a] <= closed[a] &&
                    (inputCfg[a*`CFG_FIELD_WIDTH +: `ACT_WIDTH]
                     != `ACT_NONE); // R1 R2
            end
        end
    end
endgenerate

// per loop behaviour
genvar g;
generate
    for (g = 0; g < NUM_LOOPS; g = g + 1) begin : g_loop
        integer                     i;
        reg  [`ACT_WIDTH-1:0]       act;
        reg                         mine;
        reg                         anyHand;
        reg                         anyForward;
        reg                         anySuspend;
        reg                         selHit;
        reg  [`LABEL_WIDTH-1:0]     selIdx;
        reg  [`ACT_WIDTH-1:0]       selDiff;
        reg                         handPrev;
        reg                         keyDuring;
        reg                         manualState;
        reg                         programRun;
        reg                         manualOut;
        reg                         handBlinkOut;
        reg                         remoteOut;
        reg  [`LABEL_WIDTH-1:0]     labelOut;
        reg                         spBlinkOut;
        reg                         directOut;
        reg                         advanceOut;
        reg                         suspendOut;
        wire [`CTRL_WIDTH-1:0]      ctrl;

        // base settings of this loop
        assign ctrl = loopCtrl[g];

        // gather the actions of closed inputs allocated to this loop
        always @* begin
            act         = `ACT_NONE;
            mine        = 1'b0;
            anyHand     = 1'b0;
            anyForward  = 1'b0;
            anySuspend  = 1'b0;
            selHit      = 1'b0;
            selIdx      = `LABEL_RESET;
            selDiff     = `ACT_NONE;
            // downward scan so the lowest numbered select wins
            for (i = NUM_INPUTS - 1; i >= 0; i = i - 1) begin
                act  = inputCfg[i*`CFG_FIELD_WIDTH +: `ACT_WIDTH];
                mine = (inputCfg[i*`CFG_FIELD_WIDTH + `CFG_LOOP_BIT]
                        == (g % 2 != 0)) || (NUM_LOOPS == 1); // R12
                if (closed[i] && mine) begin
                    case (act)
                        `ACT_HAND: begin
                            anyHand = 1'b1; // R4
                        end
                        `ACT_LSP_ONE, `ACT_LSP_TWO,
                        `ACT_LSP_THREE, `ACT_LSP_FOUR: begin
                            selHit = 1'b1; // R6
                            selDiff = act - `ACT_LSP_ONE;
                            selIdx  = selDiff[`LABEL_WIDTH-1:0];
                        end
                        `ACT_FORWARD: begin
                            anyForward = 1'b1; // R8
                        end
                        `ACT_SUSPEND: begin
                            anySuspend = 1'b1; // R11
                        end
                        default: begin
                            act = `ACT_NONE; // R2
                        end
                    endcase
                end
            end
        end

        // hand mode: key toggles, forcing overrides, release restores
        always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                handPrev    <= 1'b0;
                keyDuring   <= 1'b0;
                manualState <= 1'b0;
            end else begin
                handPrev <= anyHand;
                // a press seen while forced keeps hand mode later
                if (anyHand) begin
                    if (handKeyPress[g])
                        keyDuring <= 1'b1;
                end else if (handPrev) begin
                    keyDuring <= 1'b0;
                    if (keyDuring)
                        manualState <= 1'b1; // R5
                end else if (handKeyPress[g]) begin
                    manualState <= ~manualState;
                end
            end
        end

        // program run state, only the program key starts it
        always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                programRun <= 1'b0;
            end else if (progKeyPress[g]) begin
                programRun <= ~programRun; // R10
            end
        end

        // registered outputs; base state reappears once inputs open
        always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                manualOut    <= 1'b0;
                handBlinkOut <= 1'b0;
                remoteOut    <= 1'b0;
                labelOut     <= `LABEL_RESET;
                spBlinkOut   <= 1'b0;
                directOut    <= 1'b0;
                advanceOut   <= 1'b0;
                suspendOut   <= 1'b0;
            end else begin
                manualOut    <= manualState | anyHand; // R4 R3
                handBlinkOut <= anyHand; // R4
                remoteOut    <= selHit ? 1'b0
                                       : ctrl[`CTRL_REMOTE_BIT]; // R7
                labelOut     <= selHit ? selIdx
                    : ctrl[`CTRL_LSP_LSB +: `LABEL_WIDTH]; // R6 R7
                spBlinkOut   <= selHit; // R6
                directOut    <= anyForward |
                                ctrl[`CTRL_DIRECT_BIT]; // R8 R3
                advanceOut   <= programRun & ~anySuspend; // R9 R10
                suspendOut   <= anySuspend; // R9
            end
        end

        // drive this loop's slice of the output ports
        assign manualMode[g]                     = manualOut;
        assign handBlink[g]                      = handBlinkOut;
        assign remoteSetpoint[g]                 = remoteOut;
        assign setpointLabel[g*2 +: 2]           = labelOut;
        assign setpointBlink[g]                  = spBlinkOut;
        assign directAction[g]                   = directOut;
        assign programAdvance[g]                 = advanceOut;
        assign suspendBlink[g]                   = suspendOut;
    end
endgenerate

// apb decode, zero wait states
assign setupPhase  = psel & ~penable;
assign writeAccess = psel & penable & pwrite & addrHit;
assign wordAddr    = paddr[`ADDR_WIDTH-1:0];
assign pready      = 1'b1;
assign pslverr     = psel & penable & ~addrHit; // unmapped address

// address hit and read mux
always @* begin
    statusWord = 32'h0000_0000;
    statusWord[NUM_INPUTS-1:0] = closed;
    statusWord[`STAT_ANN_LSB +: NUM_INPUTS] = annunciator;
    addrHit    = 1'b1;
    readValue  = 32'h0000_0000;
    case (wordAddr)
        `REG_INPUT_CFG:  readValue = inputCfg;
        `REG_LOOP0_CTRL: readValue[`CTRL_WIDTH-1:0] = loopCtrl[0];
        `REG_LOOP1_CTRL: readValue[`CTRL_WIDTH-1:0] =
                             loopCtrl[NUM_LOOPS-1];
        `REG_STATUS:     readValue = statusWord;
        default:         addrHit = 1'b0;
    endcase
    // any bit above the decoded byte refuses the access
    if (paddr[31:`ADDR_WIDTH] != {(32-`ADDR_WIDTH){1'b0}})
        addrHit = 1'b0;
end

// per loop state byte in the status word
genvar s;
generate
    for (s = 0; s < NUM_LOOPS; s = s + 1) begin : g_stat
        assign statusWordLoop[s*`STAT_LOOP_WIDTH +: `STAT_LOOP_WIDTH] =
            {suspendBlink[s], programAdvance[s], directAction[s],
             setpointLabel[s*2 +: 2], remoteSetpoint[s],
             handBlink[s], manualMode[s]};
    end
endgenerate

// read data captured in the setup cycle, held through access
always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
        prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
        if (wordAddr == `REG_STATUS && addrHit)
            prdata <= readValue |
                ({{(32-NUM_LOOPS*`STAT_LOOP_WIDTH){1'b0}},
                  statusWordLoop} << `STAT_LOOP_LSB);
        else
            prdata <= readValue;
    end
end

// register writes at the access edge
always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
        inputCfg <= `CFG_RESET;
    end else if (writeAccess && wordAddr == `REG_INPUT_CFG) begin
        inputCfg <= pwdata; // R12
    end
end

// loop control registers, one per loop
genvar c;
generate
    for (c = 0; c < NUM_LOOPS; c = c + 1) begin : g_ctrl
        always @(posedge sys_clk or posedge reset) begin
            if (reset) begin
                loopCtrl[c] <= `CTRL_RESET;
            end else if (writeAccess &&
                         wordAddr == ((c == 0) ? `REG_LOOP0_CTRL
                                               : `REG_LOOP1_CTRL)) begin
                loopCtrl[c] <= pwdata[`CTRL_WIDTH-1:0];
            end
        end
    end
endgenerate

endmodule

/* File: tb/contact_partner.sv */
// far side model: external contacts and front panel keys
// assumes the bench gives commands in step with sys_clk
module contact_partner (
    // clock
    input  wire        sys_clk,
    // commands from the bench
    input  wire [3:0]  cmdContacts,
    input  wire [1:0]  cmdHand,
    input  wire [1:0]  cmdProg,
    // pins toward the device
    output logic [3:0] contactClosed,
    output logic [1:0] handAutoKey,
    output logic [1:0] programToggleKey
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels follow commands just after the edge, no bounce
    always @(posedge sys_clk) begin
        contactClosed    <= cmdContacts;
        handAutoKey      <= cmdHand;
        programToggleKey <= cmdProg;
    end
endmodule

/* File: tb/contact_input_mode_switcher_assertions.sv */
// checker: port level properties of the mode switcher
// assumes contacts reach outputs three edges after they are sampled
module contact_input_mode_switcher_assertions #(
    parameter NUM_INPUTS = 4,
    parameter NUM_LOOPS  = 2
) (
    // clock and reset
    input wire                  sys_clk,
    input wire                  reset,
    // apb
    input wire                  psel,
    input wire                  penable,
    input wire [31:0]           paddr,
    input wire [31:0]           prdata,
    input wire                  pready,
    input wire                  pslverr,
    // contacts and loop state
    input wire [NUM_INPUTS-1:0] contactClosed,
    input wire [NUM_INPUTS-1:0] annunciator,
    input wire [NUM_LOOPS-1:0]  manualMode,
    input wire [NUM_LOOPS-1:0]  handBlink,
    input wire [NUM_LOOPS-1:0]  remoteSetpoint,
    input wire [NUM_LOOPS-1:0]  setpointBlink,
    input wire [NUM_LOOPS-1:0]  programAdvance,
    input wire [NUM_LOOPS-1:0]  suspendBlink
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_PREADY_HIGH: assert property (pready)
        else $error("pready low");
    AST_SLVERR_MAP: assert property (pslverr == (psel && penable
        && !(paddr inside {32'h0, 32'h4, 32'h8, 32'hC})))
        else $error("pslverr wrong for address");
    AST_ANN_NEEDS_CLOSURE: assert property (
        (annunciator & ~$past(contactClosed, 3)) == '0)
        else $error("annunciator lit on open contact");
    AST_BLINK_NEEDS_CLOSURE: assert property (
        |{handBlink, setpointBlink, suspendBlink} |->
        |$past(contactClosed, 3))
        else $error("blink without closed contact");
    AST_HAND_BLINK_MANUAL: assert property (
        (handBlink & ~manualMode) == '0)
        else $error("hand blink outside hand mode");
    AST_SP_BLINK_LOCAL: assert property (
        (setpointBlink & remoteSetpoint) == '0)
        else $error("setpoint blink on remote source");
    AST_SUSPEND_HALTS: assert property (
        (suspendBlink & programAdvance) == '0)
        else $error("program advances while suspended");
    AST_STATUS_ANN: assert property (
        psel && penable && paddr == 32'hC |->
        prdata[7:4] == $past(annunciator))
        else $error("status annunciators wrong");
endmodule

bind contact_input_mode_switcher contact_input_mode_switcher_assertions #(
    .NUM_INPUTS(NUM_INPUTS), .NUM_LOOPS(NUM_LOOPS)) chk (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contactClosed(contactClosed), .annunciator(annunciator),
    .manualMode(manualMode), .handBlink(handBlink),
    .remoteSetpoint(remoteSetpoint), .setpointBlink(setpointBlink),
    .programAdvance(programAdvance), .suspendBlink(suspendBlink));

/* File: tb/contact_input_mode_switcher_tb_top.sv */
// bench top: apb master, contact partner, checks of loop outputs
// assumes the design header is on the include path
`include "mode_switch_consts.vh"
module contact_input_mode_switcher_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd, cfg;
    logic [3:0]  cmdContacts, contactClosed, annunciator, setpointLabel;
    logic [1:0]  cmdHand, cmdProg, handAutoKey, programToggleKey;
    logic [1:0]  manualMode, handBlink, remoteSetpoint, setpointBlink;
    logic [1:0]  directAction, programAdvance, suspendBlink;
    logic        err;
    int          errors, samples_checked;
    contact_input_mode_switcher uut (.sys_clk(sys_clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .contactClosed(contactClosed),
        .handAutoKey(handAutoKey), .programToggleKey(programToggleKey),
        .annunciator(annunciator), .manualMode(manualMode),
        .handBlink(handBlink), .remoteSetpoint(remoteSetpoint),
        .setpointLabel(setpointLabel), .setpointBlink(setpointBlink),
        .directAction(directAction), .programAdvance(programAdvance),
        .suspendBlink(suspendBlink));
    contact_partner far (.sys_clk(sys_clk), .cmdContacts(cmdContacts),
        .cmdHand(cmdHand), .cmdProg(cmdProg),
        .contactClosed(contactClosed), .handAutoKey(handAutoKey),
        .programToggleKey(programToggleKey));
    // clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // expected annunciators: configured and closed
    function automatic logic [3:0] expAnn(logic [31:0] c, logic [3:0] k);
        for (int i = 0; i < 4; i++) expAnn[i] = k[i] && c[4*i+:3] != 3'h0;
    endfunction
    task automatic chk(string name, logic [31:0] e, logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask
    // one apb transfer, waits on pready
    task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // access ends at the edge where pready stands high
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // contact change, then settle past the synchroniser
    task automatic setc(logic [3:0] c);
        @(posedge sys_clk);
        cmdContacts <= c;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic key(logic [1:0] h, logic [1:0] p);
        @(posedge sys_clk);
        cmdHand <= h;
        cmdProg <= p;
        repeat (4) @(posedge sys_clk);
        cmdHand <= 2'h0;
        cmdProg <= 2'h0;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic wrap_up;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end
    initial begin
        void'($urandom(27));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cmdContacts, cmdHand, cmdProg} = '0;
        reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        // reset values and refused addresses
        apb(0, `REG_INPUT_CFG, 0);
        chk("cfg reset", `CFG_RESET, rd);
        apb(0, `REG_LOOP1_CTRL, 0);
        chk("ctrl reset", `CTRL_RESET, rd);
        apb(0, 32'h10, 0);
        chk("unmapped err", 1, 32'(err));
        apb(0, 32'h100, 0);
        chk("high addr err", 1, 32'(err));
        apb(0, `REG_STATUS, 0);
        chk("status err", 0, 32'(err));
        setc(4'hF);
        chk("dark ann", 0, 32'(annunciator));
        chk("dark hand", 0, 32'(manualMode));
        chk("dark sp", 0, 32'({setpointBlink, directAction}));
        // random actions and contacts on loop zero
        repeat (8) begin
            cfg = $urandom & 32'h7777;
            apb(1, `REG_INPUT_CFG, cfg);
            apb(0, `REG_INPUT_CFG, 0);
            chk("cfg", cfg, rd);
            setc(4'($urandom));
            chk("ann", 32'(expAnn(cfg, cmdContacts)), 32'(annunciator));
            apb(0, `REG_STATUS, 0);
            chk("stat", 32'(expAnn(cfg, cmdContacts)), 32'(rd[7:4]));
            chk("stat in", 32'(cmdContacts), 32'(rd[3:0]));
        end
        apb(1, `REG_INPUT_CFG, 0);
        setc(0);
        chk("restored", 0, 32'({manualMode, directAction}));
        // hand forcing on input zero
        apb(1, `REG_INPUT_CFG, 32'h1);
        setc(1);
        chk("hand", 3, 32'({manualMode[0], handBlink[0]}));
        setc(0);
        chk("hand off", 0, 32'({manualMode, handBlink}));
        setc(1);
        key(2'h1, 2'h0);
        setc(0);
        chk("hand kept", 1, 32'(manualMode));
        key(2'h1, 2'h0);
        chk("hand key", 0, 32'(manualMode));
        // setpoint selects from a remote base
        apb(1, `REG_LOOP0_CTRL, 32'h1);
        for (int k = 0; k < 4; k++) begin
            apb(1, `REG_INPUT_CFG, 32'((k + 2) << 4));
            setc(2);
            chk("sp", 16 + k, 32'({setpointBlink, setpointLabel}));
            chk("sp src", 0, 32'(remoteSetpoint));
            setc(0);
            chk("sp back", 1, 32'({setpointBlink, remoteSetpoint}));
        end
        apb(1, `REG_LOOP0_CTRL, 32'h4);
        apb(1, `REG_INPUT_CFG, 32'h20);
        setc(2);
        chk("lsp sel", 0, 32'(setpointLabel));
        setc(0);
        chk("lsp back", 2, 32'(setpointLabel));
        // forward action allocated to loop one
        apb(1, `REG_INPUT_CFG, 32'hE00);
        setc(4);
        chk("dir", 2, 32'(directAction));
        setc(0);
        chk("dir off", 0, 32'(directAction));
        // loop one base settings and its status byte
        apb(1, `REG_LOOP1_CTRL, 32'h9);
        apb(0, `REG_LOOP1_CTRL, 0);
        chk("ctrl1", 32'h9, rd);
        chk("base1", 3, 32'({directAction[1], remoteSetpoint[1]}));
        apb(0, `REG_STATUS, 0);
        chk("stat loop1", 32'h24, 32'(rd[23:16]));
        // suspend on loop one, then loop zero
        apb(1, `REG_INPUT_CFG, 32'hF000);
        key(2'h0, 2'h2);
        chk("run", 2, 32'(programAdvance));
        setc(8);
        chk("held", 8, 32'({suspendBlink, programAdvance}));
        setc(0);
        chk("resume", 2, 32'(programAdvance));
        key(2'h0, 2'h2);
        setc(8);
        setc(0);
        chk("no resume", 0, 32'(programAdvance));
        apb(1, `REG_INPUT_CFG, 32'h7000);
        key(2'h0, 2'h1);
        setc(8);
        chk("held0", 4, 32'({suspendBlink, programAdvance}));
        wrap_up;
    end
endmodule
